// *** timu_pkg.sv ***
package timu_pkg;

  // ==========================================================================
  // bus map
  // ==========================================================================
  localparam logic [3:0] TIMU_OFS_CTRL   = 4'h0;
  localparam logic [3:0] TIMU_OFS_INSTR  = 4'h4;
  localparam logic [3:0] TIMU_OFS_FLAGS  = 4'h8;
  localparam logic [3:0] TIMU_OFS_RESULT = 4'hc;

  localparam int unsigned TIMU_GO_BIT = 0;

  // ==========================================================================
  // opcodes and timing
  // ==========================================================================
  localparam logic [7:0] TIMU_OPC_RR  = 8'h62;
  localparam logic [7:0] TIMU_OPC_RIR = 8'h63;
  localparam logic [7:0] TIMU_OPC_FR  = 8'h64;
  localparam logic [7:0] TIMU_OPC_FIR = 8'h65;
  localparam logic [7:0] TIMU_OPC_IM  = 8'h66;

  localparam logic [2:0] TIMU_CYC_SHORT = 3'h4;
  localparam logic [2:0] TIMU_CYC_LONG  = 3'h6;
  localparam logic [1:0] TIMU_BYTES_2   = 2'h2;
  localparam logic [1:0] TIMU_BYTES_3   = 2'h3;

  localparam logic [7:0] TIMU_FLAGS_RST = 8'h00;
  localparam logic [31:0] TIMU_INSTR_RST = 32'h0;

  // flag byte: c z s v d h, bits 7..2
  localparam int unsigned TIMU_FC = 7;
  localparam int unsigned TIMU_FZ = 6;
  localparam int unsigned TIMU_FS = 5;
  localparam int unsigned TIMU_FV = 4;
  localparam int unsigned TIMU_FD = 3;
  localparam int unsigned TIMU_FH = 2;

  typedef struct packed {
    logic       legal;
    logic [1:0] bytes;
    logic [2:0] cycles;
    logic       dst_first;
  } timu_dec_s;

  typedef enum logic [1:0] {
    TIMU_IDLE = 2'b00,
    TIMU_BUSY = 2'b01,
    TIMU_DONE = 2'b11
  } timu_state_e;

endpackage

// *** timu_core.sv ***
`timescale 1ns/1ps
module timu_core
  import timu_pkg::*;
(
  // operands
  input  wire logic [7:0] dst_in,
  input  wire logic [7:0] src_in,
  input  wire logic [7:0] flags_in,
  // results
  output logic      [7:0] result_out,
  output logic      [7:0] flags_out
);
  always_comb begin
    result_out = (~dst_in) & src_in;
    flags_out = flags_in;
    flags_out[TIMU_FZ] = (result_out == 8'h00);
    flags_out[TIMU_FS] = result_out[7];
    flags_out[TIMU_FV] = 1'b0;
  end
endmodule

// *** timu_top.sv ***
`timescale 1ns/1ps
module timu_top
  import timu_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // operands from the register file
  input  wire logic [7:0]  dst_in,
  input  wire logic [7:0]  src_in,
  // status
  output logic      [7:0]  flags_out,
  output logic             busy_out,
  output logic             illegal_out
);
  import timu_pkg::*;

  // ==========================================================================
  // decode
  // ==========================================================================
  function automatic timu_dec_s timu_decode(input logic [7:0] opc);
    timu_dec_s d;
    d = '{legal: 1'b1, bytes: TIMU_BYTES_3, cycles: TIMU_CYC_LONG, dst_first: 1'b0};
    case (opc)
      TIMU_OPC_RR: begin
        d.bytes = TIMU_BYTES_2;
        d.cycles = TIMU_CYC_SHORT;
        d.dst_first = 1'b1;
      end
      TIMU_OPC_RIR: begin
        d.bytes = TIMU_BYTES_2;
        d.dst_first = 1'b1;
      end
      TIMU_OPC_FR, TIMU_OPC_FIR: d.dst_first = 1'b0;
      TIMU_OPC_IM: d.dst_first = 1'b1;
      default: d.legal = 1'b0;
    endcase
    return d;
  endfunction

  // ==========================================================================
  // registers
  // ==========================================================================
  timu_state_e state_r;
  timu_state_e state_nxt;
  logic [31:0] instr_r;
  logic [31:0] instr_nxt;
  logic [7:0]  result_r;
  logic [7:0]  dst_r;
  logic [7:0]  src_r;
  logic [2:0]  cnt_r;
  logic [2:0]  cnt_nxt;
  logic        waitreq_r;
  timu_dec_s   dec;
  logic [7:0]  core_result;
  logic [7:0]  core_flags;
  logic [7:0]  mask_sel;
  logic        rd_load;
  logic        wr_take;
  logic        idle;
  logic        done;
  logic        go;
  logic        start;
  logic        instr_wr;
  logic        flags_wr;

  // ==========================================================================
  // bus helpers
  // ==========================================================================
  function automatic logic addr_hit(input logic [3:0] addr,
                                    input logic [3:0] ofs);
    return (addr == ofs);
  endfunction

  // byte lanes without an enable keep their old contents
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_word,
                                              input logic [31:0] new_word,
                                              input logic [3:0]  lanes);
    logic [31:0] word;
    word = old_word;
    for (int i = 0; i < 4; i++) begin
      if (lanes[i]) begin
        word[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    return word;
  endfunction

  function automatic logic [31:0] byte_word(input logic [7:0] b);
    return {24'h00_0000, b};
  endfunction

  function automatic logic [31:0] status_word(input logic illegal,
                                              input logic busy);
    logic [31:0] word;
    word = 32'h0000_0000;
    word[0] = busy;
    word[1] = illegal;
    return word;
  endfunction

  // ==========================================================================
  // strobes
  // ==========================================================================
  // a write lands only on the edge that sees waitrequest low, so a master that
  // drops its request early leaves no trace; read data is loaded one edge sooner
  assign rd_load  = avs_read_in && waitreq_r;
  assign wr_take  = avs_write_in && !waitreq_r;
  assign idle     = (state_r == TIMU_IDLE);
  assign done     = (state_r == TIMU_DONE);
  assign dec      = timu_decode(instr_r[7:0]);
  assign go       = wr_take && addr_hit(avs_address_in, TIMU_OFS_CTRL)
                    && avs_byteenable_in[0] && avs_writedata_in[TIMU_GO_BIT];
  assign start    = go && idle && dec.legal;
  assign instr_wr = wr_take && addr_hit(avs_address_in, TIMU_OFS_INSTR) && idle;
  assign flags_wr = wr_take && addr_hit(avs_address_in, TIMU_OFS_FLAGS)
                    && avs_byteenable_in[0] && idle;
  // immediate form takes its mask from the instruction stream, after the destination byte
  assign mask_sel = (instr_r[7:0] == TIMU_OPC_IM) ? instr_r[23:16] : src_in;

  timu_core u_core (
    .dst_in    (dst_r),
    .src_in    (src_r),
    .flags_in  (flags_out),
    .result_out(core_result),
    .flags_out (core_flags)
  );

  // ==========================================================================
  // bus: one wait state on every access, driven from a flop
  // ==========================================================================
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      waitreq_r <= 1'b1;
    end else begin
      waitreq_r <= !((avs_read_in || avs_write_in) && waitreq_r);
    end
  end
  assign avs_waitrequest_out = waitreq_r;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (rd_load) begin
      case (avs_address_in)
        TIMU_OFS_CTRL:   avs_readdata_out <= status_word(illegal_out, busy_out);
        TIMU_OFS_INSTR:  avs_readdata_out <= instr_r;
        TIMU_OFS_FLAGS:  avs_readdata_out <= byte_word(flags_out);
        TIMU_OFS_RESULT: avs_readdata_out <= byte_word(result_r);
        default:         avs_readdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // instruction word
  // ==========================================================================
  // opcode in byte 0, operand bytes 1 and 2 in stream order
  always_comb begin
    instr_nxt = instr_r;
    if (instr_wr) begin
      instr_nxt = merge_bytes(instr_r, avs_writedata_in, avs_byteenable_in);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      instr_r <= TIMU_INSTR_RST;
    end else begin
      instr_r <= instr_nxt;
    end
  end

  // ==========================================================================
  // execution sequence
  // ==========================================================================
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      TIMU_IDLE: begin
        if (start) begin
          state_nxt = TIMU_BUSY;
        end
      end
      TIMU_BUSY: begin
        if (cnt_r == 3'h1) begin
          state_nxt = TIMU_DONE;
        end
      end
      TIMU_DONE: begin
        state_nxt = TIMU_IDLE;
      end
      default: begin
        state_nxt = TIMU_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= TIMU_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================================
  // cycle counter
  // ==========================================================================
  always_comb begin
    cnt_nxt = cnt_r;
    if (start) begin
      cnt_nxt = dec.cycles - 3'h1;
    end else if (state_r == TIMU_BUSY) begin
      cnt_nxt = cnt_r - 3'h1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= 3'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // ==========================================================================
  // operand latches
  // ==========================================================================
  // operands are copied at the start edge so the pins may move while busy
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dst_r <= 8'h00;
    end else if (start) begin
      dst_r <= dst_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      src_r <= 8'h00;
    end else if (start) begin
      src_r <= mask_sel;
    end
  end

  // ==========================================================================
  // status and results
  // ==========================================================================
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= (state_nxt != TIMU_IDLE);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      illegal_out <= 1'b0;
    end else if (go && idle) begin
      illegal_out <= !dec.legal;
    end
  end

  // result reaches only the flags and result_r; operands are never written back
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flags_out <= TIMU_FLAGS_RST;
    end else if (done) begin
      flags_out <= core_flags;
    end else if (flags_wr) begin
      flags_out <= avs_writedata_in[7:0];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      result_r <= 8'h00;
    end else if (done) begin
      result_r <= core_result;
    end
  end

endmodule

// *** timu_top_properties.sv ***
`timescale 1ns/1ps
// ==========================================
// flag and timing checks
// ==========================================
module timu_checker
  import timu_pkg::*;
(
  // clock and reset
  input wire logic        clk_in,
  input wire logic        rst_in,
  // register bus
  input wire logic [3:0]  avs_address_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0]  avs_byteenable_in,
  input wire logic        avs_waitrequest_out,
  // operands and status
  input wire logic [7:0]  dst_in,
  input wire logic [7:0]  src_in,
  input wire logic [7:0]  flags_out,
  input wire logic        busy_out,
  input wire logic        illegal_out
);
  logic [7:0] opc_seen;
  logic [7:0] imm_seen;
  logic [7:0] dst_seen;
  logic [7:0] mask_seen;
  logic       wr_done;

  assign wr_done = avs_write_in && !avs_waitrequest_out;

  // operands as the block should have taken them, rebuilt from the bus and the pins
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      opc_seen  <= 8'h00;
      imm_seen  <= 8'h00;
      dst_seen  <= 8'h00;
      mask_seen <= 8'h00;
    end else if (wr_done && !busy_out) begin
      if (avs_address_in == TIMU_OFS_INSTR && avs_byteenable_in[0]) begin
        opc_seen <= avs_writedata_in[7:0];
      end
      if (avs_address_in == TIMU_OFS_INSTR && avs_byteenable_in[2]) begin
        imm_seen <= avs_writedata_in[23:16];
      end
      if (avs_address_in == TIMU_OFS_CTRL && avs_byteenable_in[0] && avs_writedata_in[0]) begin
        dst_seen  <= dst_in;
        mask_seen <= (opc_seen == TIMU_OPC_IM) ? imm_seen : src_in;
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  v_clear_a:
    assert property ($fell(busy_out) |-> !flags_out[TIMU_FV]) else $error("v left set");
  chd_keep_a:
    assert property ($fell(busy_out) |-> (flags_out & 8'h8c) == ($past(flags_out) & 8'h8c))
      else $error("c d h changed");
  zero_flag_a:
    assert property ($fell(busy_out) |->
      flags_out[TIMU_FZ] == ((~dst_seen & mask_seen) == 8'h00)) else $error("z wrong");
  sign_flag_a:
    assert property ($fell(busy_out) |->
      flags_out[TIMU_FS] == (~dst_seen[7] & mask_seen[7])) else $error("s wrong");
  busy_min_a:
    assert property ($rose(busy_out) |-> busy_out[*4]) else $error("busy too short");
  busy_max_a:
    assert property ($rose(busy_out) |-> ##[4:6] !busy_out) else $error("busy too long");
  illegal_idle_a:
    assert property (illegal_out |-> !busy_out) else $error("illegal op ran");
  flags_hold_a:
    assert property (busy_out && $past(busy_out) |-> $stable(flags_out)) else $error("flags moved");
endmodule
bind timu_top timu_checker u_chk (.clk_in, .rst_in, .avs_address_in, .avs_write_in,
  .avs_writedata_in, .avs_byteenable_in, .avs_waitrequest_out, .dst_in, .src_in, .flags_out,
  .busy_out, .illegal_out);

// *** test_complement_under_mask_tb.sv ***
`timescale 1ns/1ps
module test_complement_under_mask_tb;
  import timu_pkg::*;
  logic        clk_in = 0, rst_in = 1, avs_read_in = 0, avs_write_in = 0;
  logic [3:0]  avs_address_in = '0, avs_byteenable_in = 4'hf;
  logic [31:0] avs_writedata_in = '0, avs_readdata_out, q, seed = 32'h04f07da3;
  logic        avs_waitrequest_out, busy_out, illegal_out;
  logic [7:0]  dst_in = '0, src_in = '0, flags_out, pre, f;
  logic [7:0]  ops[5] = '{TIMU_OPC_RR, TIMU_OPC_RIR, TIMU_OPC_FR, TIMU_OPC_FIR, TIMU_OPC_IM};
  int          errors = 0, num_checks = 0, n;
  always #2 clk_in = ~clk_in;
  timu_top DUT (.clk_in, .rst_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
    .dst_in, .src_in, .flags_out, .busy_out, .illegal_out);
  // ==========================================
  // helpers
  // ==========================================
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded waits: a hang counts as a mismatch
  task automatic guard();
    n++;
    if (n > 40) begin
      errors++;
      report_and_stop();
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    // one edge between requests, so a strobe is never driven twice in a time step
    @(posedge clk_in);
    avs_address_in   <= a;
    avs_writedata_in <= d;
    avs_write_in     <= w;
    avs_read_in      <= !w;
    n = 0;
    do begin
      @(posedge clk_in);
      guard();
    end while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
  endtask
  // model: result and flags from integers
  task automatic run(input logic [7:0] op, input logic [7:0] d, input logic [7:0] s);
    int r, e, c;
    r = int'(~d & s);
    dst_in <= d;
    // the immediate form must take its mask from the instruction, not the pin
    src_in <= (op == TIMU_OPC_IM) ? ~s : s;
    pre = 8'(rnd() & 32'hfc);
    bus(1'b1, TIMU_OFS_FLAGS, {24'h0, pre});
    bus(1'b1, TIMU_OFS_INSTR, {8'h0, (op == TIMU_OPC_IM) ? s : ~s, d, op});
    bus(1'b1, TIMU_OFS_CTRL, 32'h1);
    c = 0;
    n = 0;
    while (c == 0 || busy_out === 1'b1) begin
      @(posedge clk_in);
      if (busy_out === 1'b1) c++;
      guard();
    end
    e = (pre & 'h8c) | ((r == 0) << TIMU_FZ) | (((r >> 7) & 1) << TIMU_FS);
    chk(c, (op == TIMU_OPC_RR) ? 4 : 6);
    chk(flags_out, e);
    chk({busy_out, illegal_out}, 2'b00);
    bus(1'b0, TIMU_OFS_RESULT, 32'h0);
    chk(q, r);
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    run(TIMU_OPC_RR, 8'hc7, 8'h02);
    run(TIMU_OPC_IM, 8'h2b, 8'h34);
    run(TIMU_OPC_FR, 8'h00, 8'hff);
    run(TIMU_OPC_FIR, 8'hff, 8'h00);
    for (int i = 0; i < 20; i++) begin
      run(ops[i % 5], 8'(rnd()), 8'(rnd()));
    end
    f = flags_out;
    bus(1'b1, TIMU_OFS_INSTR, 32'h72);
    bus(1'b1, TIMU_OFS_CTRL, 32'h1);
    repeat (3) @(posedge clk_in);
    chk({busy_out, illegal_out, flags_out}, {2'b01, f});
    bus(1'b0, TIMU_OFS_CTRL, 32'h0);
    chk(q, 32'h2);
    bus(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    report_and_stop();
  end
endmodule
